// >>> hw/tcu_pkg.sv
/*
 * Constants, register map, field layout and carrier types of the timer
 * compare unit. Assumes one 200 MHz system clock, synchronous low reset
 * and a plain single-cycle register port with byte-wide data.
 */
// Behaviour
// - compare value against timer count every cycle
// - mode field picks pin high, low, unchanged
// - match sets channel flag one clock later
// - zero control write clears compare latch only
// - software interrupt mode only sets flag
// - first channel trigger clears timer count
// - second channel trigger clears count, starts conversion
// - trigger clear never sets overflow flag
// - flag/enable: compare bit 2, overflow bit 0
// - control: duty bits 5:4, mode 3:0
// - timer control fields, top bits zero
// - second channel mirrors first except trigger
package tcu_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TMR_W = 16;
	localparam int unsigned NUM_CH = 2;
	localparam int unsigned EVT_W = 4;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PORTC = 8'h07;
	localparam logic [7:0] OFS_INTCTL = 8'h0b;
	localparam logic [7:0] OFS_PFLAG = 8'h0c;
	localparam logic [7:0] OFS_CH2FLAG = 8'h0d;
	localparam logic [7:0] OFS_TMR_LO = 8'h0e;
	localparam logic [7:0] OFS_TMR_HI = 8'h0f;
	localparam logic [7:0] OFS_TIMER_CONTROL = 8'h10;
	localparam logic [7:0] OFS_CMP0_LO = 8'h15;
	localparam logic [7:0] OFS_CMP0_HI = 8'h16;
	localparam logic [7:0] OFS_CTL0 = 8'h17;
	localparam logic [7:0] OFS_CMP1_LO = 8'h1b;
	localparam logic [7:0] OFS_CMP1_HI = 8'h1c;
	localparam logic [7:0] OFS_CTL1 = 8'h1d;
	localparam logic [7:0] OFS_EVT = 8'h20;
	localparam logic [7:0] OFS_EVT_MASK = 8'h21;
	localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h87;
	localparam logic [7:0] OFS_PIE = 8'h8c;
	localparam logic [7:0] OFS_CH2EN = 8'h8d;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned GIE_BIT = 7;
	localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6;
	localparam int unsigned CMP_FLAG_BIT = 2;
	localparam int unsigned OVF_FLAG_BIT = 0;
	localparam int unsigned CH2_FLAG_BIT = 0;
	localparam int unsigned T1_ON_BIT = 0;
	localparam int unsigned T1_CS_BIT = 1;
	localparam int unsigned T1_PS_LSB = 4;
	localparam int unsigned PIN_CH0 = 2;
	localparam int unsigned PIN_CH1 = 1;
	localparam int unsigned EVT_CMP0 = 0;
	localparam int unsigned EVT_CMP1 = 1;
	localparam int unsigned EVT_OVF = 2;
	localparam int unsigned EVT_TRIG = 3;

	// ----------------------------------------------------------------
	// compare modes of the low control nibble
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_SET_HI = 4'h8;
	localparam logic [3:0] MODE_SET_LO = 4'h9;
	localparam logic [3:0] MODE_SW_IRQ = 4'ha;
	localparam logic [3:0] MODE_TRIG = 4'hb;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE0 = 8'h00;
	localparam logic [5:0] RST_CTL = 6'h00;
	localparam logic [5:0] RST_TIMER_CONTROL = 6'h00;
	localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
	localparam logic [15:0] RST_TMR = 16'h0000;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} tcu_reg_req_s;

	typedef struct packed {
		logic [7:0] intctl;
		logic [7:0] pflag;
		logic [7:0] pie;
		logic ch2flag;
		logic ch2en;
		logic [TMR_W-1:0] tmr;
		logic [5:0] timer_control;
		logic [NUM_CH-1:0][TMR_W-1:0] cmp;
		logic [NUM_CH-1:0][5:0] ctl;
		logic [NUM_CH-1:0] latch;
		logic [NUM_CH-1:0] hit_prev;
		logic [7:0] port_c_direction;
		logic [7:0] portc;
		logic [2:0] pre_cnt;
		logic ext_prev;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_mask;
		logic [DATA_W-1:0] rd_data;
		logic [7:0] pin;
		logic [7:0] pin_oe;
		logic adc_start;
		logic cmp_irq;
		logic irq;
	} tcu_state_s;

	localparam tcu_state_s STATE_RST = '{
		intctl: RST_BYTE0,
		pflag: RST_BYTE0,
		pie: RST_BYTE0,
		tmr: RST_TMR,
		timer_control: RST_TIMER_CONTROL,
		ctl: {RST_CTL, RST_CTL},
		port_c_direction: RST_PORT_C_DIRECTION,
		portc: RST_BYTE0,
		default: '0
	};

endpackage : tcu_pkg

// >>> hw/tcu_compare.sv
/*
 * Timer compare unit: 16-bit timer with prescaler, two compare channels
 * with pin drive, flag, software interrupt and special event trigger,
 * port C pin mux and a read-clear event status with mask.
 * Assumes synchronous inputs, one clock, and a register master that never
 * raises read and write strobes together.
 */
module tcu_compare #(
	parameter int unsigned NUM_CH = tcu_pkg::NUM_CH
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire tcu_pkg::tcu_reg_req_s reg_req_i,
	output logic [tcu_pkg::DATA_W-1:0] rd_data_o,
	// timer external count input and converter handshake
	input wire logic t_ext_i,
	input wire logic adc_enable_i,
	output logic adc_start_o,
	// port C pins
	output logic [7:0] portc_o,
	output logic [7:0] portc_oe_o,
	// interrupts
	output logic cmp_irq_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// the register map only has room for two channels
	if (NUM_CH != tcu_pkg::NUM_CH) begin : g_bad_ch
		$error("tcu_compare supports exactly two channels");
	end
	// the byte port and the two-byte timer are fixed by the map
	if (tcu_pkg::DATA_W != 8) begin : g_bad_data
		$error("tcu_compare needs a byte-wide register port");
	end
	if (tcu_pkg::TMR_W != 2 * tcu_pkg::DATA_W) begin : g_bad_tmr
		$error("tcu_compare needs a two-byte timer");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tcu_pkg::tcu_state_s q;
	tcu_pkg::tcu_state_s d;

	// per-channel decode
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] first;
	logic [NUM_CH-1:0] cmp_mode;
	logic [NUM_CH-1:0] trig;
	logic [NUM_CH-1:0][3:0] mode;
	logic [NUM_CH-1:0][7:0] pin_bit;

	// timer decode
	logic src_evt;
	logic tick;
	logic tmr_wr;
	logic ovf;
	logic [2:0] pre_max;
	logic [7:0] addr;
	logic [7:0] wdata;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.adc_start = 1'b0;
		d.rd_data = '0;
		addr = reg_req_i.addr;
		wdata = reg_req_i.wdata;
		pin_bit[0] = 8'h01 << tcu_pkg::PIN_CH0;
		pin_bit[1] = 8'h01 << tcu_pkg::PIN_CH1;

		// ------------------------------------------------------------
		// match detection
		// ------------------------------------------------------------
		// a stopped or slow timer holds equality for many clocks;
		// hit_prev keeps every action to the first of them
		// match detection, once per equality run
		for (int c = 0; c < NUM_CH; c++) begin
			mode[c] = q.ctl[c][3:0];
			hit[c] = (q.tmr == q.cmp[c]);
			first[c] = hit[c] & ~q.hit_prev[c];
			d.hit_prev[c] = hit[c];
			cmp_mode[c] = (mode[c][3:2] == 2'b10);
			trig[c] = first[c] & cmp_mode[c] &
				(mode[c] == tcu_pkg::MODE_TRIG);
		end

		// ------------------------------------------------------------
		// compare latch
		// ------------------------------------------------------------
		// pin latch action on a fresh match
		for (int c = 0; c < NUM_CH; c++) begin
			if (first[c] && cmp_mode[c]) begin
				case (mode[c])
				tcu_pkg::MODE_SET_HI: begin
					d.latch[c] = 1'b1;
				end
				tcu_pkg::MODE_SET_LO: begin
					d.latch[c] = 1'b0;
				end
				// software interrupt leaves the pin alone
				tcu_pkg::MODE_SW_IRQ: begin
					d.latch[c] = q.latch[c];
				end
				// the trigger acts on the timer, not the pin
				tcu_pkg::MODE_TRIG: begin
					d.latch[c] = q.latch[c];
				end
				default: begin
					d.latch[c] = q.latch[c];
				end
				endcase
			end
		end

		// ------------------------------------------------------------
		// prescaler and timer
		// ------------------------------------------------------------
		// limitation: all counting is synchronous to clk_sys_i
		// prescaler: internal source counts every clock,
		// external source counts rising edges of t_ext_i
		d.ext_prev = t_ext_i;
		if (q.timer_control[tcu_pkg::T1_CS_BIT]) begin
			src_evt = t_ext_i & ~q.ext_prev;
		end else begin
			src_evt = 1'b1;
		end
		pre_max = 3'((4'h1 << q.timer_control[tcu_pkg::T1_PS_LSB +: 2]) - 4'h1);
		tick = 1'b0;
		if (q.timer_control[tcu_pkg::T1_ON_BIT] && src_evt) begin
			if (q.pre_cnt == pre_max) begin
				tick = 1'b1;
				d.pre_cnt = '0;
			end else begin
				d.pre_cnt = q.pre_cnt + 3'h1;
			end
		end

		// a trigger clear that lands on a timer write is dropped; the
		// write is what software asked for, so it wins
		// timer: software write beats trigger beats count
		tmr_wr = reg_req_i.wr &&
			(addr == tcu_pkg::OFS_TMR_LO || addr == tcu_pkg::OFS_TMR_HI);
		ovf = 1'b0;
		if (tmr_wr) begin
			d.pre_cnt = '0;
			if (addr == tcu_pkg::OFS_TMR_LO) begin
				d.tmr[7:0] = wdata;
			end else begin
				d.tmr[15:8] = wdata;
			end
		end else if (|trig) begin
			// trigger clear is no overflow
			d.tmr = '0;
			d.pre_cnt = '0;
		end else if (tick) begin
			d.tmr = q.tmr + 16'h0001;
			ovf = (q.tmr == '1);
		end

		// ------------------------------------------------------------
		// converter start
		// ------------------------------------------------------------
		// the enable is sampled in the match cycle, nothing is queued
		// conversion start only while the converter is on
		d.adc_start = trig[1] & adc_enable_i;

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		if (reg_req_i.wr) begin
			case (addr)
			tcu_pkg::OFS_PORTC: begin
				d.portc = wdata;
			end
			tcu_pkg::OFS_INTCTL: begin
				d.intctl = wdata;
			end
			tcu_pkg::OFS_PFLAG: begin
				// only the two flags of this block are kept
				d.pflag = '0;
				d.pflag[tcu_pkg::CMP_FLAG_BIT] =
					wdata[tcu_pkg::CMP_FLAG_BIT];
				d.pflag[tcu_pkg::OVF_FLAG_BIT] =
					wdata[tcu_pkg::OVF_FLAG_BIT];
			end
			tcu_pkg::OFS_CH2FLAG: begin
				d.ch2flag = wdata[tcu_pkg::CH2_FLAG_BIT];
			end
			tcu_pkg::OFS_TIMER_CONTROL: begin
				d.timer_control = wdata[5:0];
			end
			tcu_pkg::OFS_CMP0_LO: begin
				d.cmp[0][7:0] = wdata;
			end
			tcu_pkg::OFS_CMP0_HI: begin
				d.cmp[0][15:8] = wdata;
			end
			tcu_pkg::OFS_CTL0: begin
				d.ctl[0] = wdata[5:0];
				if (wdata == '0) begin
					d.latch[0] = 1'b0;
				end
			end
			tcu_pkg::OFS_CMP1_LO: begin
				d.cmp[1][7:0] = wdata;
			end
			tcu_pkg::OFS_CMP1_HI: begin
				d.cmp[1][15:8] = wdata;
			end
			tcu_pkg::OFS_CTL1: begin
				d.ctl[1] = wdata[5:0];
				if (wdata == '0) begin
					d.latch[1] = 1'b0;
				end
			end
			tcu_pkg::OFS_EVT_MASK: begin
				d.evt_mask = wdata[tcu_pkg::EVT_W-1:0];
			end
			tcu_pkg::OFS_PORT_C_DIRECTION: begin
				d.port_c_direction = wdata;
			end
			tcu_pkg::OFS_PIE: begin
				d.pie = wdata;
			end
			tcu_pkg::OFS_CH2EN: begin
				d.ch2en = wdata[tcu_pkg::CH2_FLAG_BIT];
			end
			default: begin
				d.portc = d.portc; // unmapped writes are dropped
			end
			endcase
		end

		// ------------------------------------------------------------
		// register reads, data one cycle later
		// ------------------------------------------------------------
		if (reg_req_i.rd) begin
			case (addr)
			tcu_pkg::OFS_PORTC: d.rd_data = q.portc;
			tcu_pkg::OFS_INTCTL: d.rd_data = q.intctl;
			tcu_pkg::OFS_PFLAG: d.rd_data = q.pflag;
			tcu_pkg::OFS_CH2FLAG: d.rd_data = {7'h00, q.ch2flag};
			tcu_pkg::OFS_TMR_LO: d.rd_data = q.tmr[7:0];
			tcu_pkg::OFS_TMR_HI: d.rd_data = q.tmr[15:8];
			tcu_pkg::OFS_TIMER_CONTROL: d.rd_data = {2'b00, q.timer_control};
			tcu_pkg::OFS_CMP0_LO: d.rd_data = q.cmp[0][7:0];
			tcu_pkg::OFS_CMP0_HI: d.rd_data = q.cmp[0][15:8];
			tcu_pkg::OFS_CTL0: d.rd_data = {2'b00, q.ctl[0]};
			tcu_pkg::OFS_CMP1_LO: d.rd_data = q.cmp[1][7:0];
			tcu_pkg::OFS_CMP1_HI: d.rd_data = q.cmp[1][15:8];
			tcu_pkg::OFS_CTL1: d.rd_data = {2'b00, q.ctl[1]};
			tcu_pkg::OFS_EVT: begin
				// reading the event status clears it
				d.rd_data = {4'h0, q.evt};
				d.evt = '0;
			end
			tcu_pkg::OFS_EVT_MASK: d.rd_data = {4'h0, q.evt_mask};
			tcu_pkg::OFS_PORT_C_DIRECTION: d.rd_data = q.port_c_direction;
			tcu_pkg::OFS_PIE: d.rd_data = q.pie;
			tcu_pkg::OFS_CH2EN: d.rd_data = {7'h00, q.ch2en};
			default: d.rd_data = '0;
			endcase
		end

		// ------------------------------------------------------------
		// hardware flag sets, placed after writes so a set wins
		// ------------------------------------------------------------
		if (first[0] && cmp_mode[0]) begin
			d.pflag[tcu_pkg::CMP_FLAG_BIT] = 1'b1;
			d.evt[tcu_pkg::EVT_CMP0] = 1'b1;
		end
		if (first[1] && cmp_mode[1]) begin
			d.ch2flag = 1'b1;
			d.evt[tcu_pkg::EVT_CMP1] = 1'b1;
		end
		if (ovf) begin
			d.pflag[tcu_pkg::OVF_FLAG_BIT] = 1'b1;
			d.evt[tcu_pkg::EVT_OVF] = 1'b1;
		end
		if (|trig) begin
			d.evt[tcu_pkg::EVT_TRIG] = 1'b1;
		end

		// ------------------------------------------------------------
		// pins: compare latch owns its bit in drive modes only
		// ------------------------------------------------------------
		d.pin = d.portc;
		for (int c = 0; c < NUM_CH; c++) begin
			if (d.ctl[c][3:0] == tcu_pkg::MODE_SET_HI ||
					d.ctl[c][3:0] == tcu_pkg::MODE_SET_LO) begin
				d.pin = (d.pin & ~pin_bit[c]) |
					(d.latch[c] ? pin_bit[c] : 8'h00);
			end
		end
		// no direction override: software must clear the bit itself
		// a set direction bit leaves the pin undriven
		d.pin_oe = ~d.port_c_direction;

		// ------------------------------------------------------------
		// interrupt requests
		// ------------------------------------------------------------
		d.cmp_irq = d.intctl[tcu_pkg::GIE_BIT] &
			d.intctl[tcu_pkg::PERIPHERAL_IRQ_ENABLE_BIT] &
			((d.pflag[tcu_pkg::CMP_FLAG_BIT] &
				d.pie[tcu_pkg::CMP_FLAG_BIT]) |
			(d.ch2flag & d.ch2en));
		// event line: any unmasked sticky status bit, one clock
		// after the event, like every other output
		d.irq = |(d.evt & d.evt_mask);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// synchronous reset puts every field at its documented value;
	// the register port may be used in the first cycle after it
	// and a reset in mid-run drops any pending match action
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q <= tcu_pkg::STATE_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	// nothing combinational reaches a pin, so no glitch leaves
	assign rd_data_o = q.rd_data;
	assign adc_start_o = q.adc_start;
	assign portc_o = q.pin;
	assign portc_oe_o = q.pin_oe;
	assign cmp_irq_o = q.cmp_irq;
	assign irq_o = q.irq;

endmodule : tcu_compare

// >>> tb/tcu_chk.sv
/*
 * Port checker of the timer compare unit, bound to the top module.
 * Assumes a single-cycle register port and one synchronous clock.
 */
module tcu_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// watched ports
	input wire tcu_pkg::tcu_reg_req_s reg_req_i,
	input wire logic [tcu_pkg::DATA_W-1:0] rd_data_o,
	input wire logic adc_enable_i,
	input wire logic adc_start_o,
	input wire logic [7:0] portc_oe_o,
	input wire logic cmp_irq_o,
	input wire logic irq_o
);
	// ----------------------------------------------------------------
	// read and write address, 3f when idle (unmapped)
	// ----------------------------------------------------------------
	logic [7:0] ra;
	logic [7:0] wa;
	assign ra = reg_req_i.rd ? reg_req_i.addr : 8'h3f;
	assign wa = reg_req_i.wr ? reg_req_i.addr : 8'h3f;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_rd_idle: assert property (!$past(reg_req_i.rd) |-> rd_data_o == 8'h00)
		else $error("read data without a read");
	chk_ctl_top: assert property (
		$past(ra) == tcu_pkg::OFS_CTL0 |-> rd_data_o[7:6] == 2'b00)
		else $error("control top bits not zero");
	chk_tcon_top: assert property (
		$past(ra) == tcu_pkg::OFS_TIMER_CONTROL |-> rd_data_o[7:6] == 2'b00)
		else $error("timer control top bits not zero");
	chk_flag_bits: assert property (
		$past(ra) == tcu_pkg::OFS_PFLAG |-> (rd_data_o & 8'hfa) == 8'h00)
		else $error("unused flag bits set");
	chk_unmapped_zero: assert property (
		$past(reg_req_i.rd) && $past(ra) == 8'h3f |-> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	chk_start_pulse: assert property (
		adc_start_o |=> !adc_start_o) else $error("start longer than one");
	chk_start_enable: assert property (
		adc_start_o |-> $past(adc_enable_i)) else $error("start while off");
	chk_irq_fall: assert property (
		$fell(irq_o) |-> $past(ra) == tcu_pkg::OFS_EVT
		|| $past(ra, 2) == tcu_pkg::OFS_EVT
		|| $past(wa) == tcu_pkg::OFS_EVT_MASK
		|| $past(wa, 2) == tcu_pkg::OFS_EVT_MASK)
		else $error("event irq fell without read or mask");
	chk_flag_hold: assert property (
		$fell(cmp_irq_o) |-> $past(reg_req_i.wr) || $past(reg_req_i.wr, 2))
		else $error("compare request fell without a write");
	chk_dir_hold: assert property (
		!$stable(portc_oe_o) |-> $past(wa) == tcu_pkg::OFS_PORT_C_DIRECTION
		|| $past(wa, 2) == tcu_pkg::OFS_PORT_C_DIRECTION)
		else $error("output enables moved without write");
endmodule : tcu_chk

bind tcu_compare tcu_chk u_chk (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.reg_req_i(reg_req_i),
	.rd_data_o(rd_data_o),
	.adc_enable_i(adc_enable_i),
	.adc_start_o(adc_start_o),
	.portc_oe_o(portc_oe_o),
	.cmp_irq_o(cmp_irq_o),
	.irq_o(irq_o)
);

// >>> tb/tcu_pin_load.sv
/*
 * Far-side load: the line on the compare pin and a converter start count.
 * Assumes the pin and its enable come registered from the unit.
 */
module tcu_pin_load (
	// clock
	input wire logic clk_sys_i,
	// from the unit
	input wire logic pin_i,
	input wire logic pin_oe_i,
	input wire logic adc_start_i,
	// observed side
	output logic line_o,
	output int adc_cnt_o
);
	// an undriven line sinks to the weak pull-down, never the last level
	assign line_o = pin_oe_i ? pin_i : 1'b0;

	// converter counts every start pulse it sees
	initial adc_cnt_o = 0;
	always @(posedge clk_sys_i) begin
		if (adc_start_i === 1'b1) begin
			adc_cnt_o <= adc_cnt_o + 1;
		end
	end
endmodule : tcu_pin_load

// >>> tb/tb_timer_compare_unit.sv
/*
 * Self-checking bench of the timer compare unit with the pin load model.
 * Assumes the checker bind and a 200 MHz clock.
 */
module tb_timer_compare_unit;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	tcu_pkg::tcu_reg_req_s req = '0;
	logic adc_en = 1'b0;
	logic [7:0] rdata;
	logic [7:0] pc;
	logic [7:0] oe;
	logic adc_start;
	logic cmp_irq;
	logic irq;
	logic line;
	int adc_cnt;
	int bad_count = 0;
	int checks_done = 0;

	initial forever #2.5 clk_sys_i = ~clk_sys_i;

	tcu_compare dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.reg_req_i(req), .rd_data_o(rdata), .t_ext_i(1'b0),
		.adc_enable_i(adc_en), .adc_start_o(adc_start), .portc_o(pc),
		.portc_oe_o(oe), .cmp_irq_o(cmp_irq), .irq_o(irq));
	tcu_pin_load u_load (.clk_sys_i(clk_sys_i), .pin_i(pc[2]),
		.pin_oe_i(oe[2]), .adc_start_i(adc_start), .line_o(line),
		.adc_cnt_o(adc_cnt));

	// bus cycles and comparison helpers
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i);
		req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i);
		req <= '0;
		#1 d = rdata;
	endtask : rd
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rc(string n, logic [7:0] a, logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(n, e, d);
	endtask : rc
	// bounded wait for a level, counted as one comparison
	task automatic wt(ref logic s, input logic v, input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			#1;
			if (s === v) break;
		end
		chk("wait", {7'h0, v}, {7'h0, s});
	endtask : wt

	// reset values, read-only bits and an unmapped place
	task automatic t_reset;
		rc("pflag", 8'h0c, 8'h00);
		rc("pie", 8'h8c, 8'h00);
		rc("ctl", 8'h17, 8'h00);
		rc("tcon", 8'h10, 8'h00);
		rc("port_c_direction", 8'h87, 8'hff);
		wr(8'h17, 8'hf0);
		rc("ctl", 8'h17, 8'h30);
		wr(8'h10, 8'hfe);
		rc("tcon", 8'h10, 8'h3e);
		wr(8'h10, 8'h00);
		rc("unmapped", 8'h3f, 8'h00);
	endtask : t_reset

	// drive modes, single action per equality, latch ownership
	task automatic t_drive;
		logic [7:0] m[2] = '{8'h09, 8'h08};
		wr(8'h87, 8'hfb);
		wr(8'h15, 8'h04);
		wr(8'h16, 8'h00);
		wr(8'h0f, 8'h00);
		wr(8'h0e, 8'h00);
		wr(8'h17, 8'h08);
		wr(8'h10, 8'h31);
		wt(line, 1'b1, 100);
		rc("flag set", 8'h0c, 8'h04);
		wr(8'h0c, 8'h00);
		rc("flag once", 8'h0c, 8'h00);
		wr(8'h10, 8'h00);
		chk("dir", 8'h04, oe & 8'h04);
		foreach (m[i]) begin
			wr(8'h17, m[i]);
			wr(8'h0e, 8'h00);
			wr(8'h10, 8'h01);
			wt(line, ~m[i][0], 60);
			wr(8'h10, 8'h00);
		end
		// latch is high now; port latch must take over off drive modes
		wr(8'h07, 8'h04);
		wr(8'h17, 8'h00);
		wt(line, 1'b1, 3);
		wr(8'h17, 8'h08);
		wt(line, 1'b0, 3);
		wr(8'h07, 8'h00);
	endtask : t_drive

	// flag only, request gated by the enables
	task automatic t_swirq;
		logic [7:0] d;
		wr(8'h0c, 8'h00);
		rd(8'h20, d);
		wr(8'h0b, 8'hc0);
		wr(8'h21, 8'h01);
		wr(8'h17, 8'h0a);
		wr(8'h0e, 8'h00);
		wr(8'h10, 8'h01);
		wt(irq, 1'b1, 30);
		wr(8'h10, 8'h00);
		rc("swi flag", 8'h0c, 8'h04);
		chk("swi pin", 8'h00, {7'h0, line});
		chk("no req", 8'h00, {7'h0, cmp_irq});
		wr(8'h8c, 8'h04);
		wt(cmp_irq, 1'b1, 4);
		wr(8'h0c, 8'h00);
		wt(cmp_irq, 1'b0, 4);
		rd(8'h20, d);
		chk("evt", 8'h01, d & 8'h0f);
		wt(irq, 1'b0, 4);
	endtask : t_swirq

	// first channel trigger clears the count
	task automatic t_trig0;
		logic [7:0] d;
		wr(8'h21, 8'h08);
		wr(8'h17, 8'h0b);
		wr(8'h15, 8'h03);
		wr(8'h0e, 8'h00);
		wr(8'h10, 8'h01);
		wt(irq, 1'b1, 30);
		wr(8'h10, 8'h00);
		rd(8'h0e, d);
		chk("period", 8'h00, d & 8'hfc);
		rc("cnt hi", 8'h0f, 8'h00);
		rd(8'h20, d);
		chk("evt", 8'h09, d & 8'h0d);
	endtask : t_trig0

	// second channel trigger: full 16-bit match and converter start
	task automatic t_trig1;
		logic [7:0] d;
		wr(8'h17, 8'h00);
		wr(8'h0c, 8'h00);
		wr(8'h1b, 8'h05);
		wr(8'h1c, 8'h01);
		wr(8'h1d, 8'h0b);
		@(posedge clk_sys_i);
		adc_en <= 1'b1;
		wr(8'h0e, 8'h00);
		wr(8'h10, 8'h01);
		wt(adc_start, 1'b1, 300);
		wr(8'h10, 8'h00);
		chk("starts", 8'h01, adc_cnt[7:0]);
		rc("ch2 flag", 8'h0d, 8'h01);
		rd(8'h0c, d);
		chk("ovf", 8'h00, d & 8'h01);
		rd(8'h20, d);
		chk("evt", 8'h0a, d & 8'h0e);
		rc("cnt hi", 8'h0f, 8'h00);
	endtask : t_trig1

	task automatic summarize;
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// watchdog: under a thousand cycles are needed, 40000 allowed
	initial begin
		#200000;
		bad_count++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_drive();
		t_swirq();
		t_trig0();
		t_trig1();
		summarize();
	end
endmodule : tb_timer_compare_unit
